// ==== shared/cmo_pkg.sv ====
/*
 Package for the control micro-operator block: register map of the APB
 slave, opcode and field layouts, variant codes and reset values.
 Assumes 32-bit APB data with one register to an aligned word.
*/
package cmo_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CMO_OFS_MICRO   = 8'h00; // Micro word, write issues it
    localparam logic [7:0] CMO_OFS_CTRL    = 8'h04; // Mode and condition inputs
    localparam logic [7:0] CMO_OFS_WORK    = 8'h08; // Wide work register
    localparam logic [7:0] CMO_OFS_PORTCH  = 8'h0C; // Port/channel register
    localparam logic [7:0] CMO_OFS_MEMLOW  = 8'h10; // Memory word, bits 0..23
    localparam logic [7:0] CMO_OFS_XCHG    = 8'h14; // Interchange port/channel
    localparam logic [7:0] CMO_OFS_STATUS  = 8'h18; // Interchange status bits
    localparam logic [7:0] CMO_OFS_RESULT  = 8'h1C; // Result of last micro
    localparam logic [7:0] CMO_OFS_BUFCAP  = 8'h20; // Buffer capture register
    localparam logic [7:0] CMO_OFS_FIELD   = 8'h24; // Field address register
    localparam logic [7:0] CMO_OFS_NANOSEL = 8'h28; // Nano word slice select
    localparam logic [7:0] CMO_OFS_DIAG    = 8'h2C; // Diagnostic field decode

    // ------------------------------------------------------------------
    // Opcodes and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] CMO_OP_DISPATCH = 12'h001;
    localparam logic [11:0] CMO_OP_CASSETTE = 12'h002;
    localparam logic [15:0] CMO_OP_HALT     = 16'h0001;
    localparam logic [15:0] CMO_OP_NOP      = 16'h0000;
    localparam logic [7:0]  CMO_OP_MONITOR  = 8'h09;
    localparam logic [7:0]  CMO_OP_NANOMOVE = 8'h0A;
    localparam logic [7:0]  CMO_OP_DIAGMEM  = 8'h0B;
    localparam int CMO_VAR_LSB   = 1;   // Dispatch/cassette variant bits 3..1
    localparam int CMO_FLAG_BIT  = 0;   // Skip variant / halt-skip flag
    localparam int CMO_STOP_LSB  = 3;   // Nano stopping number bits 6..3
    localparam int CMO_ABORT_BIT = 7;
    localparam int CMO_WIDE      = 24;
    localparam int CMO_PC_W      = 7;
    localparam int CMO_NANO_W    = 168;

    // Dispatch variants
    localparam logic [2:0] CMO_DV_LOCK   = 3'h0;
    localparam logic [2:0] CMO_DV_WRLO   = 3'h1;
    localparam logic [2:0] CMO_DV_READ   = 3'h2;
    localparam logic [2:0] CMO_DV_RDCLR  = 3'h3;
    localparam logic [2:0] CMO_DV_WRHI   = 3'h4;
    localparam logic [2:0] CMO_DV_ABSENT = 3'h5;

    // Status bit positions
    localparam int CMO_ST_LOCK = 0;
    localparam int CMO_ST_INT  = 1;
    localparam int CMO_ST_HIGH = 2;
    localparam int CMO_ST_MISS = 3;

    // Control register bits
    localparam int CMO_CT_DIRECT = 0;
    localparam int CMO_CT_TAPE   = 1;
    localparam int CMO_CT_XEQY   = 2;
    localparam int CMO_CT_GAP    = 3;

    localparam logic [31:0] CMO_RESET_WORD = 32'h0000_0000;
endpackage : cmo_pkg

// ==== verilog/cmo_nano_slice.sv ====
/*
 Selects one 24-bit group of the nano word by a 4-bit portion code.
 Assumes the nano word is held stable by the caller while selected.
*/
`timescale 1ns/1ps
module cmo_nano_slice
    import cmo_pkg::*;
#(
    parameter int NANO_W = CMO_NANO_W
) (
    // Nano word and portion code
    input  wire logic [NANO_W-1:0] i_nano,
    input  wire logic [3:0]        i_code,
    // Selected group
    output logic      [23:0]       o_slice,
    output logic                   o_defined
);
    // Codes above six are undefined and read zero
    assign o_defined = (i_code < 4'h7);
    assign o_slice   = o_defined ? i_nano[i_code*24 +: 24] : 24'h000000;
endmodule : cmo_nano_slice

// ==== verilog/cmo_tape_ctl.sv ====
/*
 Cassette motion: start at once, stop only at the next inter-record gap.
 Assumes the gap indication is a synchronous level from the drive.
*/
`timescale 1ns/1ps
module cmo_tape_ctl (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    // Requests
    input  wire logic i_start,
    input  wire logic i_stop,
    input  wire logic i_gap,
    // Motion
    output logic      o_running
);
    logic run_r;
    logic stop_pend_r;

    // Stop waits for a gap so a record is never cut in half
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_r       <= 1'b0;
            stop_pend_r <= 1'b0;
        end else if (i_start) begin
            run_r       <= 1'b1;
            stop_pend_r <= 1'b0;
        end else if ((i_stop || stop_pend_r) && run_r) begin
            run_r       <= !i_gap;
            stop_pend_r <= !i_gap;
        end
    end
    assign o_running = run_r;
endmodule : cmo_tape_ctl

// ==== verilog/cmo_micro_ctl.sv ====
/*
 Control micro-operator unit: dispatch through the port interchange,
 cassette control, halt, no-op, monitor strobes, nano move and the
 diagnostic field decode, with its state reached over APB.
 Assumes one 100 MHz clock and an APB master that holds each transfer.
*/
// How it works
// - Dispatch decoded by opcode 001 and 3-bit variant.
// - Lockout sets lock; skip chosen by skip bit on lock held or not.
// - Write sets lock and interrupt, stores work and port, sets high bit on write-high only.
// - Read loads memory to work and low 7 port bits only.
// - Read-clear also clears lock, both interrupts and absent bit.
// - Port-absent drives the absent level to the requester.
// - Direct connect: lockout skips, write low absent, read-clear present.
// - Direct connect keeps work and port; lock, interrupt and high bits held clear.
// - Cassette variant decode: start, stop, compare stops, reserved.
// - Flag picks halt or skip; tape mode halts on any stop.
// - Tape stops at the next inter-record gap.
// - Run-mode halt fetches next micro before stopping.
// - Tape-mode halt stops without fetching, clears micro register.
// - All-zero opcode is a no-operation.
// - Monitor strobes opcode and two low bits, gated with clock.
// - Nano move takes one clock and changes only nano select and its arm flag.
// - Next micro freezes at stopping step; slice goes to buffer.
// - Abort bit raises suppress at the freeze; buffer replaced.
// - Step 1 stop suppresses execution; later steps complete first.
// - Portion code 0..6 selects 24-bit groups; others undefined.
// - Diagnostic micro fields: register, sign, target, direction.
`timescale 1ns/1ps
module cmo_micro_ctl
    import cmo_pkg::*;
#(
    parameter int NANO_W = CMO_NANO_W
) (
    // Clock and reset
    input  wire logic              I_CLK,
    input  wire logic              I_ARST_N,
    // APB slave
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [7:0]        I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    // Sequencer and nano word
    input  wire logic [3:0]        I_SEQ_STEP,
    input  wire logic [3:0]        I_SEQ_COUNT,
    input  wire logic [NANO_W-1:0] I_NANO_WORD,
    // Backplane and processor outputs
    output logic                   O_PORT_ABSENT,
    output logic                   O_SKIP,
    output logic                   O_HALT,
    output logic                   O_FETCH_NEXT,
    output logic                   O_FREEZE,
    output logic                   O_SUPPRESS,
    output logic                   O_MON_OP,
    output logic      [3:0]        O_MON_BITS,
    output logic                   O_TAPE_RUN
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] micro_r;
    logic [3:0]  ctrl_r;
    logic [23:0] work_r, portch_r, memlow_r, field_r, bufcap_r;
    logic [6:0]  xchg_r;
    logic [3:0]  status_r;
    logic [2:0]  result_r;   // {halt, skip, absent level}
    logic        nano_arm_r;
    logic        nano_wait_r;
    logic [7:0]  nano_cfg_r;
    logic        freeze_r;
    logic        halt_r;
    logic        skip_r;
    logic        issue_r;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire apb_acc = I_PSEL && I_PENABLE;
    wire apb_wr  = apb_acc && I_PWRITE;
    wire known   = (I_PADDR[1:0] == 2'h0) && (I_PADDR <= CMO_OFS_DIAG);
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = apb_acc && !known;
    wire wr_micro  = apb_wr && (I_PADDR == CMO_OFS_MICRO);
    wire wr_ctrl   = apb_wr && (I_PADDR == CMO_OFS_CTRL);
    wire wr_work   = apb_wr && (I_PADDR == CMO_OFS_WORK);
    wire wr_portch = apb_wr && (I_PADDR == CMO_OFS_PORTCH);
    wire wr_memlow = apb_wr && (I_PADDR == CMO_OFS_MEMLOW);
    wire wr_field  = apb_wr && (I_PADDR == CMO_OFS_FIELD);

    // ------------------------------------------------------------------
    // Micro decode
    // ------------------------------------------------------------------
    wire [2:0] var3    = micro_r[CMO_VAR_LSB +: 3];
    wire       flag    = micro_r[CMO_FLAG_BIT];
    wire       direct  = ctrl_r[CMO_CT_DIRECT];
    wire       tape    = ctrl_r[CMO_CT_TAPE];
    wire       is_disp = issue_r && (micro_r[15:4] == CMO_OP_DISPATCH);
    wire       is_cass = issue_r && (micro_r[15:4] == CMO_OP_CASSETTE);
    wire       is_halt = issue_r && (micro_r == CMO_OP_HALT);
    wire       is_nop  = issue_r && (micro_r == CMO_OP_NOP);
    wire       is_mon  = issue_r && (micro_r[15:8] == CMO_OP_MONITOR);
    wire       is_nano = issue_r && (micro_r[15:8] == CMO_OP_NANOMOVE);
    wire       is_diag = micro_r[15:8] == CMO_OP_DIAGMEM;

    // Dispatch strobes
    wire lock_skip_strobe  = is_disp && (var3 == CMO_DV_LOCK);
    wire write_low_strobe  = is_disp && (var3 == CMO_DV_WRLO);
    wire write_high_strobe = is_disp && (var3 == CMO_DV_WRHI);
    wire read_strobe       = is_disp && (var3 == CMO_DV_READ);
    wire read_clear_strobe = is_disp && (var3 == CMO_DV_RDCLR);
    wire absent_strobe     = is_disp && (var3 == CMO_DV_ABSENT);
    wire any_write         = write_low_strobe || write_high_strobe;
    wire any_read          = read_strobe || read_clear_strobe;
    // Variants 6 and 7 fall through every strobe above untouched

    // Lockout skip: skip bit 0 skips when already held, 1 when won
    wire lock_held   = status_r[CMO_ST_LOCK];
    wire lock_skip   = direct ? 1'b1 : (flag ? !lock_held : lock_held);

    // Cassette decode
    wire x_eq_y      = ctrl_r[CMO_CT_XEQY];
    wire fa_eq_br    = (field_r == bufcap_r);
    wire cass_start  = is_cass && (var3 == 3'h0);
    wire cass_cond   = is_cass && var3[1] && (var3 != 3'h4);
    wire cond_hit    = var3[0] ? (var3[2] ? fa_eq_br : !fa_eq_br)
                               : (var3[2] ? x_eq_y : !x_eq_y);
    wire cass_stop   = is_cass && ((var3 == 3'h1) || (cass_cond && cond_hit));
    wire cass_skip   = cass_stop && cass_cond && flag && !tape;
    wire cass_halt   = cass_stop && (tape || !(cass_cond && flag));

    // Diagnostic decode, exposed read-only
    function automatic logic [4:0] diag_fields(input logic [7:0] f);
        diag_fields = {f[7:6], f[5], f[3], f[2]};
    endfunction : diag_fields
    wire [4:0] diag_dec = is_diag ? diag_fields(micro_r[7:0]) : 5'h00;

    // Nano portion selection
    logic [23:0] nano_slice;
    logic        nano_def;
    cmo_nano_slice #(.NANO_W(NANO_W)) u_slice (
        .i_nano    (I_NANO_WORD),
        .i_code    ({1'b0, nano_cfg_r[2:0]}),
        .o_slice   (nano_slice),
        .o_defined (nano_def)
    );
    wire [3:0] stop_num = nano_cfg_r[CMO_STOP_LSB +: 4];
    wire nano_hit = nano_wait_r && (I_SEQ_STEP == stop_num);

    // ------------------------------------------------------------------
    // Issue and micro register
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            micro_r <= CMO_RESET_WORD[15:0];
            issue_r <= 1'b0;
        end else begin
            issue_r <= wr_micro;
            if (wr_micro)
                micro_r <= I_PWDATA[15:0];
            else if (is_halt && tape)
                micro_r <= CMO_OP_NOP;
        end
    end

    // Control register
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N)
            ctrl_r <= CMO_RESET_WORD[3:0];
        else if (wr_ctrl)
            ctrl_r <= I_PWDATA[3:0];
    end

    // ------------------------------------------------------------------
    // Work and port/channel registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            work_r   <= CMO_RESET_WORD[23:0];
            portch_r <= CMO_RESET_WORD[23:0];
            memlow_r <= CMO_RESET_WORD[23:0];
            field_r  <= CMO_RESET_WORD[23:0];
        end else begin
            if (wr_work)
                work_r <= I_PWDATA[23:0];
            else if (any_read && !direct)
                work_r <= memlow_r;
            if (wr_portch)
                portch_r <= I_PWDATA[23:0];
            else if (any_read && !direct)
                portch_r <= {portch_r[23:7], xchg_r};
            if (wr_memlow)
                memlow_r <= I_PWDATA[23:0];
            else if (any_write && !direct)
                memlow_r <= work_r;
            if (wr_field)
                field_r <= I_PWDATA[23:0];
        end
    end

    // ------------------------------------------------------------------
    // Interchange state
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            xchg_r   <= CMO_RESET_WORD[6:0];
            status_r <= CMO_RESET_WORD[3:0];
        end else if (direct) begin
            status_r[2:0] <= 3'h0;
            if (write_low_strobe)
                status_r[CMO_ST_MISS] <= 1'b1;
            else if (read_clear_strobe)
                status_r[CMO_ST_MISS] <= 1'b0;
        end else if (any_write) begin
            status_r[CMO_ST_LOCK] <= 1'b1;
            status_r[CMO_ST_INT]  <= 1'b1;
            status_r[CMO_ST_HIGH] <= write_high_strobe;
            xchg_r                <= portch_r[6:0];
        end else if (lock_skip_strobe) begin
            status_r[CMO_ST_LOCK] <= 1'b1;
        end else if (read_clear_strobe) begin
            status_r <= 4'h0;
        end else if (absent_strobe) begin
            status_r[CMO_ST_MISS] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Skip, halt and result
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            skip_r <= 1'b0;
            halt_r <= 1'b0;
        end else begin
            skip_r <= (lock_skip_strobe && lock_skip) || cass_skip;
            if (is_halt || cass_halt)
                halt_r <= 1'b1;
            else if (wr_micro)
                halt_r <= 1'b0;
        end
    end
    assign result_r = {halt_r, skip_r, status_r[CMO_ST_MISS]};

    // ------------------------------------------------------------------
    // Nano move: arm, freeze, capture
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            nano_arm_r  <= 1'b0;
            nano_wait_r <= 1'b0;
            nano_cfg_r <= CMO_RESET_WORD[7:0];
            freeze_r   <= 1'b0;
            bufcap_r   <= CMO_RESET_WORD[23:0];
        end else begin
            if (is_nano) begin
                nano_arm_r <= 1'b1;
                nano_cfg_r <= micro_r[7:0];
            end else if (issue_r && nano_arm_r) begin
                nano_arm_r  <= 1'b0;
                nano_wait_r <= 1'b1;
            end else if (nano_hit) begin
                nano_wait_r <= 1'b0;
            end
            freeze_r <= nano_hit;
            if (nano_hit)
                bufcap_r <= nano_def ? nano_slice : 24'h000000;
        end
    end

    // ------------------------------------------------------------------
    // Cassette motion
    // ------------------------------------------------------------------
    cmo_tape_ctl u_tape (
        .i_clk     (I_CLK),
        .i_arst_n  (I_ARST_N),
        .i_start   (cass_start),
        .i_stop    (cass_stop),
        .i_gap     (ctrl_r[CMO_CT_GAP]),
        .o_running (O_TAPE_RUN)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign O_PORT_ABSENT = status_r[CMO_ST_MISS];
    assign O_SKIP        = skip_r;
    assign O_HALT        = halt_r;
    assign O_FETCH_NEXT  = halt_r && !tape;
    assign O_FREEZE      = freeze_r;
    // Abort raises suppress at the freeze; a step-1 stop skips the micro body
    assign O_SUPPRESS    = freeze_r && (nano_cfg_r[CMO_ABORT_BIT]
                                        || stop_num == 4'h1);
    // Strobes gated with the clock as the backplane expects
    assign O_MON_OP      = is_mon && I_CLK;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_mon
            assign O_MON_BITS[g] = is_mon && I_CLK && (micro_r[1:0] == 2'(g));
        end
    endgenerate

    // Read data mux
    always_comb begin
        O_PRDATA = 32'h0000_0000;
        if (apb_acc && !I_PWRITE) begin
            case (I_PADDR)
                CMO_OFS_MICRO:   O_PRDATA = {16'h0000, micro_r};
                CMO_OFS_CTRL:    O_PRDATA = {28'h0000000, ctrl_r};
                CMO_OFS_WORK:    O_PRDATA = {8'h00, work_r};
                CMO_OFS_PORTCH:  O_PRDATA = {8'h00, portch_r};
                CMO_OFS_MEMLOW:  O_PRDATA = {8'h00, memlow_r};
                CMO_OFS_XCHG:    O_PRDATA = {25'h0000000, xchg_r};
                CMO_OFS_STATUS:  O_PRDATA = {28'h0000000, status_r};
                CMO_OFS_RESULT:  O_PRDATA = {29'h00000000, result_r};
                CMO_OFS_BUFCAP:  O_PRDATA = {8'h00, bufcap_r};
                CMO_OFS_FIELD:   O_PRDATA = {8'h00, field_r};
                CMO_OFS_NANOSEL: O_PRDATA = {24'h000000, nano_cfg_r};
                CMO_OFS_DIAG:    O_PRDATA = {27'h0000000, diag_dec};
                default:         O_PRDATA = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_lock_sets: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        lock_skip_strobe && !direct |=> status_r[CMO_ST_LOCK])
        else $error("lockout did not set lock");
    a_write_int: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        any_write && !direct |=> status_r[1:0] == 2'h3 &&
        status_r[CMO_ST_HIGH] == $past(write_high_strobe))
        else $error("dispatch write flags wrong");
    a_read_low: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        any_read && !direct && !wr_portch |=>
        portch_r[23:7] == $past(portch_r[23:7]))
        else $error("upper port bits changed");
    a_rdclr_zero: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        read_clear_strobe && !direct |=> status_r == 4'h0)
        else $error("read clear left flags");
    a_absent_lvl: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        absent_strobe && !direct |=> O_PORT_ABSENT)
        else $error("absent level not driven");
    a_direct_skip: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        lock_skip_strobe && direct |=> O_SKIP)
        else $error("direct lockout did not skip");
    a_direct_keep: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        direct && is_disp && !wr_work |=> $stable(work_r) && status_r[2:0] == 3'h0)
        else $error("direct dispatch changed work");
    a_undef_var: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        is_disp && var3[2:1] == 2'h3 && !direct |=> $stable(status_r))
        else $error("undefined dispatch changed state");
    a_tape_halt: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        cass_stop && tape |=> O_HALT ##0 !O_SKIP)
        else $error("tape mode stop did not halt");
endmodule : cmo_micro_ctl

// ==== tb/cmo_port_peer.sv ====
/*
 Far-side peer: sequencer step source, nano word and absent watcher.
 Assumes it shares the block's clock.
*/
`timescale 1ns/1ps
module cmo_port_peer
    import cmo_pkg::*;
(
    // Clock and absent level from the block
    input  wire logic                  i_clk,
    input  wire logic                  i_absent,
    // Sequencer and nano word
    output logic      [3:0]            o_step,
    output logic      [CMO_NANO_W-1:0] o_nano,
    // Absent level seen at least once
    output logic                       o_seen
);
    // Step wraps 1..8 so stopping numbers 1 to 8 come round
    initial begin
        o_step = 4'h1;
        o_seen = 1'b0;
        // Every group differs so a wrong portion shows up
        for (int k = 0; k < 7; k++)
            o_nano[k*24 +: 24] = 24'(24'h111111 * (k + 1));
    end
    always @(posedge i_clk) begin
        o_step <= (o_step == 4'h8) ? 4'h1 : o_step + 4'h1;
        if (i_absent === 1'b1) o_seen <= 1'b1;
    end
endmodule : cmo_port_peer

// ==== tb/control_micro_operators_tb.sv ====
/*
 Bench: APB tasks issue micros and read state back.
 Assumes zero-wait APB and results two cycles after issue.
*/
`timescale 1ns/1ps
module control_micro_operators_tb import cmo_pkg::*; ;
    logic clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, err, seen;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, q;
    logic rdy, slv, absent, skip, halt, fnx, run, mop, frz, sup;
    logic [3:0] step, mb;
    logic [CMO_NANO_W-1:0] nano;
    logic [4:0] mon = 5'h00;
    int bad_count = 0, check_count = 0, skips = 0, frzs = 0, sups = 0, i;
    always #5 clk = ~clk;
    always @(posedge clk) if (skip === 1'b1) skips++;
    always @(posedge clk) if (frz === 1'b1) frzs++;
    always @(posedge clk) if (sup === 1'b1) sups++;
    // Strobes are gated with the clock, so look while it is high
    always @(posedge clk) #2 mon = mon | {mop, mb};
    cmo_port_peer peer_u (.i_clk(clk), .i_absent(absent), .o_step(step), .o_nano(nano),
        .o_seen(seen));
    cmo_micro_ctl dut_u (.I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy),
        .O_PSLVERR(slv), .I_SEQ_STEP(step), .I_SEQ_COUNT(4'h1), .I_NANO_WORD(nano),
        .O_PORT_ABSENT(absent), .O_SKIP(skip), .O_HALT(halt), .O_FETCH_NEXT(fnx),
        .O_FREEZE(frz), .O_SUPPRESS(sup), .O_MON_OP(mop), .O_MON_BITS(mb), .O_TAPE_RUN(run));
    // Hold the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = prd;
        err = slv;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rdc
    task automatic issue(input logic [15:0] m);
        mon = 5'h00;
        apb(1'b1, CMO_OFS_MICRO, {16'h0, m});
        repeat (3) @(posedge clk);
    endtask : issue
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        #100000;
        bad_count++;
        final_report;
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rdc(CMO_OFS_STATUS, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        issue(16'h0010);
        issue(16'h0010);
        issue(16'h0011);
        chk(skips, 32'h1);
        apb(1'b1, CMO_OFS_WORK, 32'hABCDEF);
        apb(1'b1, CMO_OFS_PORTCH, 32'h123456);
        issue(16'h0018);
        rdc(CMO_OFS_MEMLOW, 32'hABCDEF);
        rdc(CMO_OFS_XCHG, 32'h56);
        rdc(CMO_OFS_STATUS, 32'h7);
        apb(1'b1, CMO_OFS_WORK, 32'h0);
        apb(1'b1, CMO_OFS_PORTCH, 32'hFFFF80);
        issue(16'h0014);
        rdc(CMO_OFS_WORK, 32'hABCDEF);
        rdc(CMO_OFS_PORTCH, 32'hFFFFD6);
        issue(16'h0012);
        issue(16'h001C);
        issue(16'h001E);
        rdc(CMO_OFS_STATUS, 32'h3);
        issue(16'h001A);
        chk({30'h0, absent, seen}, 32'h3);
        issue(16'h0016);
        rdc(CMO_OFS_STATUS, 32'h0);
        rdc(CMO_OFS_MEMLOW, 32'hABCDEF);
        $display("dispatch test done");
        apb(1'b1, CMO_OFS_CTRL, 32'h1);
        apb(1'b1, CMO_OFS_WORK, 32'h111111);
        issue(16'h0010);
        chk(skips, 32'h2);
        issue(16'h0012);
        rdc(CMO_OFS_STATUS, 32'h8);
        issue(16'h0014);
        rdc(CMO_OFS_WORK, 32'h111111);
        issue(16'h0016);
        chk({31'h0, absent}, 32'h0);
        $display("direct test done");
        apb(1'b1, CMO_OFS_CTRL, 32'h0);
        issue(16'h0001);
        chk({30'h0, halt, fnx}, 32'h3);
        apb(1'b1, CMO_OFS_CTRL, 32'h2);
        issue(16'h0001);
        chk({30'h0, halt, fnx}, 32'h2);
        rdc(CMO_OFS_MICRO, 32'h0);
        issue(16'h0022);
        chk({31'h0, halt}, 32'h1);
        issue(16'h0000);
        chk({31'h0, halt}, 32'h0);
        apb(1'b1, CMO_OFS_CTRL, 32'h4);
        issue(16'h0020);
        issue(16'h002D);
        issue(16'h0025);
        chk(skips, 32'h3);
        chk({31'h0, run}, 32'h1);
        apb(1'b1, CMO_OFS_CTRL, 32'hC);
        repeat (2) @(posedge clk);
        chk({31'h0, run}, 32'h0);
        $display("halt and tape test done");
        for (i = 0; i < 4; i++) begin
            issue({8'h09, 6'h0, i[1:0]});
            chk({27'h0, mon}, {27'h0, 1'b1, 4'h1 << i});
        end
        $display("monitor test done");
        issue(16'h0A91);
        issue(16'h0000);
        repeat (10) @(posedge clk);
        rdc(CMO_OFS_BUFCAP, 32'h222222);
        chk(frzs, 32'h1);
        chk(sups, 32'h1);
        issue(16'h0A0E);
        issue(16'h0000);
        repeat (10) @(posedge clk);
        rdc(CMO_OFS_BUFCAP, 32'h777777);
        chk(sups, 32'h2);
        issue(16'h0BA4);
        rdc(CMO_OFS_DIAG, 32'h15);
        $display("nano and diagnostic test done");
        final_report;
    end
endmodule : control_micro_operators_tb
